// ==== core/dcc_params.svh ====
/*
 * Register offsets, field positions, reset values and frame counts of the
 * channel update and clamp control block.
 * Assumes it is included by its bare name by package-aware design files.
 */
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

`define DCC_ADDR_SYNC      7'h15
`define DCC_ADDR_SPAN      7'h16
`define DCC_ADDR_CLAMP     7'h17
`define DCC_ADDR_SLP_A     7'h18
`define DCC_ADDR_SLP_B     7'h19
`define DCC_ADDR_ALARM     7'h1a
`define DCC_ADDR_TRIG      7'h1c
`define DCC_ADDR_DATA0     7'h30
`define DCC_ADDR_DATA_LAST 7'h37

`define DCC_NCH            8
`define DCC_NGRP           6
`define DCC_NBIP           4
`define DCC_CLAMP_RST      6'h3f
`define DCC_CFG_RST        8'h00
`define DCC_CODE_RST       12'h000
`define DCC_LATCHED_REL_BIT 6
`define DCC_AMP_BIT        7
`define DCC_TRIG_BIT       0

`define DCC_ADDR_LAST_BIT  5'h07
`define DCC_FRAME_LAST_BIT 5'h17
`define DCC_FRAME_BITS     5'h18

`endif

// ==== core/dcc_pkg.sv ====
/*
 * Types shared by the channel update and clamp control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcc_pkg;
    typedef logic [11:0] dcc_code_t;
    typedef logic [6:0]  dcc_addr_t;
    typedef enum logic [1:0] {
        DCC_SPAN_0_TO_5  = 2'b00,
        DCC_SPAN_M5_TO_0 = 2'b01,
        DCC_SPAN_M4_TO_1 = 2'b10
    } dcc_span_e;
endpackage

// ==== core/dcc_serial_port.sv ====
/*
 * Four-wire serial register port: 24-bit frames, read flag then 7-bit
 * address then 16 data bits, most significant first, sampled on rising clock.
 * Assumes the serial clock is at most one eighth of the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

module dcc_serial_port (
    // System side
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // Serial pins
    input  wire logic              sclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              mosi_in,
    output logic                   miso_out,
    output logic                   miso_oe_out,
    // Register access
    output logic                   wr_stb_out,
    output logic                   rd_stb_out,
    output dcc_pkg::dcc_addr_t     addr_out,
    output logic [15:0]            wdata_out,
    input  wire logic [15:0]       rdata_in
);
    import dcc_pkg::*;

    logic [2:0]  meta_r;
    logic [2:0]  sync_r;
    logic        sclk_d_r;
    logic [4:0]  cnt_r;
    logic [22:0] shin_r;
    logic [15:0] shout_r;
    logic        rise;
    logic        fall;

    // Pins pass two flops before any edge logic looks at them
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r   <= 3'h2;
            sync_r   <= 3'h2;
            sclk_d_r <= 1'b0;
        end else begin
            meta_r   <= {sclk_in, cs_n_in, mosi_in};
            sync_r   <= meta_r;
            sclk_d_r <= sync_r[2];
        end
    end

    assign rise        = ~sync_r[1] & sync_r[2] & ~sclk_d_r;
    assign fall        = ~sync_r[1] & ~sync_r[2] & sclk_d_r;
    assign miso_oe_out = ~sync_r[1];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r      <= 5'h00;
            shin_r     <= 23'h000000;
            rd_stb_out <= 1'b0;
            wr_stb_out <= 1'b0;
            addr_out   <= 7'h00;
            wdata_out  <= 16'h0000;
        end else begin
            rd_stb_out <= rise && cnt_r == `DCC_ADDR_LAST_BIT && shin_r[6];
            wr_stb_out <= rise && cnt_r == `DCC_FRAME_LAST_BIT && !shin_r[22];
            if (sync_r[1]) begin
                cnt_r <= 5'h00;
            end else if (rise && cnt_r != `DCC_FRAME_BITS) begin
                cnt_r  <= cnt_r + 5'h01;
                shin_r <= {shin_r[21:0], sync_r[0]};
            end
            if (rise && cnt_r == `DCC_ADDR_LAST_BIT) begin
                addr_out <= {shin_r[5:0], sync_r[0]};
            end
            if (rise && cnt_r == `DCC_FRAME_LAST_BIT) begin
                wdata_out <= {shin_r[14:0], sync_r[0]};
            end
        end
    end

    // Read data is captured the cycle after the address strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shout_r  <= 16'h0000;
            miso_out <= 1'b0;
        end else if (sync_r[1]) begin
            shout_r  <= 16'h0000;
            miso_out <= 1'b0;
        end else if (rd_stb_out) begin
            shout_r <= rdata_in;
        end else if (fall && cnt_r > `DCC_ADDR_LAST_BIT) begin
            miso_out <= shout_r[15];
            shout_r  <= {shout_r[14:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// ==== core/dcc_dac_control.sv ====
/*
 * Update and clamp control for eight 12-bit channels: four bipolar in two
 * pairs, four auxiliary. Registers sit behind the four-wire serial port.
 * Assumes the analog side uses channel_clamp_out to switch each output to its clamp and
 * pair_clamp_to_supply_out to pick the negative supply over the ref pin.
 */
// What this block does
// - Each auxiliary channel picks its own span, low or high, in the span register.
// - Auxiliary channels power up and clamp to analog ground, never configurable.
// - Eight 12-bit straight-binary data registers, one per channel.
// - Host data writes land first in a per-channel buffer register.
// - Reading a data register returns the active value, not the buffer.
// - Per-channel update mode; immediate mode copies buffer to active on write.
// - Synchronized channels move buffer to active together on register or pin trigger.
// - Entering clamp switches the output at once; buffer and active are kept.
// - Data writes are accepted during clamp and used after release.
// - Leaving clamp drives the active value at once in any update mode.
// - Pair A clamps from ref pin A, pair B from ref pin B, or supply in fault.
// - Software clamp register: one bit per pair and per aux channel, 1 clamps.
// - A positive bipolar supply fault clamps all bipolar channels to the negative supply.
// - Software clamp writes are ignored for groups held by a sleep pin.
// - A high sleep pin clamps at once the groups in its mask register.
// - Sleep pins and masks also drive the amplifier enable output.
// - With the latched release bit set, release needs pin low then a clamp write.
// - With the latched release bit clear, pin low releases the clamp by itself.
// - An alarm rise clamps the groups in the alarm mask; alarm fall does not release.
// - Reset clamps every channel and loads default codes into buffer and active.
// - Each bipolar pair picks span 0..5 V, -5..0 V or -4..1 V.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

module dcc_dac_control (
    // Clock and reset
    input  wire logic                       clk_sys_in,
    input  wire logic                       resetn_in,
    // Serial register port
    input  wire logic                       sclk_in,
    input  wire logic                       cs_n_in,
    input  wire logic                       mosi_in,
    output logic                            miso_out,
    output logic                            miso_oe_out,
    // Control pins
    input  wire logic                       converter_update_trigger_in,
    input  wire logic                       sleep_pin_a_in,
    input  wire logic                       sleep_pin_b_in,
    input  wire logic                       alarm_output_in,
    input  wire logic                       supply_fault_in,
    // Channel outputs
    output dcc_pkg::dcc_code_t [7:0]        channel_code_out,
    output logic [7:0]                      channel_clamp_out,
    output logic [1:0]                      pair_clamp_to_supply_out,
    output dcc_pkg::dcc_span_e [1:0]        pair_span_out,
    output logic [3:0]                      aux_span_high_out,
    output logic                            amplifier_enable_out
);
    import dcc_pkg::*;

    logic                 rst_meta_r;
    logic                 rst_n_r;
    logic [4:0]           pin_meta_r;
    logic [4:0]           pin_sync_r;
    logic                 trig_pin_d_r;
    logic                 alarm_d_r;
    logic                 trig_s;
    logic                 slp_a_s;
    logic                 slp_b_s;
    logic                 alarm_s;
    logic                 fault_s;
    logic                 wr_stb;
    logic                 rd_stb;
    dcc_addr_t            addr;
    logic [15:0]          wdata;
    logic [15:0]          rdata;
    logic                 data_hit;
    logic                 trig_pulse;
    logic                 alarm_rise;
    logic [7:0]           sync_mode_r;
    logic [7:0]           span_r;
    logic [7:0]           mask_a_r;
    logic [7:0]           mask_b_r;
    logic [7:0]           alarm_mask_r;
    logic [5:0]           sw_clamp_r;
    logic [5:0]           sleep_force;
    logic [5:0]           grp_clamp;
    dcc_code_t [7:0]      buf_r;
    dcc_code_t [7:0]      buf_nxt;
    dcc_code_t [7:0]      active_r;
    logic [7:0]           wr_ch;

    // Reset is released through two flops
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_meta_r   <= 5'h00;
            pin_sync_r   <= 5'h00;
            trig_pin_d_r <= 1'b0;
            alarm_d_r    <= 1'b0;
        end else begin
            pin_meta_r   <= {converter_update_trigger_in, sleep_pin_a_in, sleep_pin_b_in,
                             alarm_output_in, supply_fault_in};
            pin_sync_r   <= pin_meta_r;
            trig_pin_d_r <= pin_sync_r[4];
            alarm_d_r    <= pin_sync_r[1];
        end
    end

    assign trig_s     = pin_sync_r[4];
    assign slp_a_s    = pin_sync_r[3];
    assign slp_b_s    = pin_sync_r[2];
    assign alarm_s    = pin_sync_r[1];
    assign fault_s    = pin_sync_r[0];
    assign alarm_rise = alarm_s & ~alarm_d_r;

    dcc_serial_port u_port (
        .clk_in      (clk_sys_in),
        .rst_n_in    (rst_n_r),
        .sclk_in     (sclk_in),
        .cs_n_in     (cs_n_in),
        .mosi_in     (mosi_in),
        .miso_out    (miso_out),
        .miso_oe_out (miso_oe_out),
        .wr_stb_out  (wr_stb),
        .rd_stb_out  (rd_stb),
        .addr_out    (addr),
        .wdata_out   (wdata),
        .rdata_in    (rdata)
    );

    assign data_hit = addr >= `DCC_ADDR_DATA0 && addr <= `DCC_ADDR_DATA_LAST;

    // Trigger bit is never stored, so it reads back as zero
    assign trig_pulse = (wr_stb && addr == `DCC_ADDR_TRIG && wdata[`DCC_TRIG_BIT])
                        || (trig_s && !trig_pin_d_r);

    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sync_mode_r  <= `DCC_CFG_RST;
            span_r       <= `DCC_CFG_RST;
            mask_a_r     <= `DCC_CFG_RST;
            mask_b_r     <= `DCC_CFG_RST;
            alarm_mask_r <= `DCC_CFG_RST;
        end else if (wr_stb) begin
            case (addr)
                `DCC_ADDR_SYNC:  sync_mode_r  <= wdata[7:0];
                `DCC_ADDR_SPAN:  span_r       <= wdata[7:0];
                `DCC_ADDR_SLP_A: mask_a_r     <= wdata[7:0];
                `DCC_ADDR_SLP_B: mask_b_r     <= wdata[7:0];
                `DCC_ADDR_ALARM: alarm_mask_r <= wdata[7:0];
                default: ;
            endcase
        end
    end

    // Groups: 0 pair A, 1 pair B, 2..5 aux channels 1..4
    genvar g;
    generate
        for (g = 0; g < `DCC_NGRP; g = g + 1) begin : g_grp
            logic hold_set;
            assign sleep_force[g] = (slp_a_s & mask_a_r[g]) | (slp_b_s & mask_b_r[g]);
            // Latched release keeps the software bit set behind the pin
            assign hold_set = (slp_a_s & mask_a_r[g] & mask_a_r[`DCC_LATCHED_REL_BIT])
                            | (slp_b_s & mask_b_r[g] & mask_b_r[`DCC_LATCHED_REL_BIT]);
            assign grp_clamp[g] = sw_clamp_r[g] | sleep_force[g];

            // Set sources win over a host clear in the same cycle
            always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    sw_clamp_r[g] <= 1'(`DCC_CLAMP_RST >> g);
                end else if (hold_set || (alarm_rise && alarm_mask_r[g])) begin
                    sw_clamp_r[g] <= 1'b1;
                end else if (wr_stb && addr == `DCC_ADDR_CLAMP && !sleep_force[g]) begin
                    sw_clamp_r[g] <= wdata[g];
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < `DCC_NCH; c = c + 1) begin : g_ch
            localparam int GRP = (c < `DCC_NBIP) ? c / 2 : c - 2;
            assign wr_ch[c]   = wr_stb && data_hit && addr[2:0] == 3'(c);
            assign buf_nxt[c] = wr_ch[c] ? wdata[11:0] : buf_r[c];

            always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    buf_r[c]    <= `DCC_CODE_RST;
                    active_r[c] <= `DCC_CODE_RST;
                end else begin
                    buf_r[c] <= buf_nxt[c];
                    if ((wr_ch[c] && !sync_mode_r[c]) || (trig_pulse && sync_mode_r[c])) begin
                        active_r[c] <= buf_nxt[c];
                    end
                end
            end

            // Clamp never touches the codes, so release shows active at once
            assign channel_code_out[c] = active_r[c];

            always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    channel_clamp_out[c] <= 1'b1;
                end else begin
                    channel_clamp_out[c] <= grp_clamp[GRP] || (c < `DCC_NBIP && fault_s);
                end
            end
        end
    endgenerate

    // Aux channels clamp to analog ground, fixed in the analog path
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pair_clamp_to_supply_out <= 2'h0;
            pair_span_out[0]         <= DCC_SPAN_0_TO_5;
            pair_span_out[1]         <= DCC_SPAN_0_TO_5;
            aux_span_high_out        <= 4'h0;
        end else begin
            pair_clamp_to_supply_out <= {2{fault_s}};
            pair_span_out[0]         <= (span_r[1:0] == 2'h3) ? DCC_SPAN_0_TO_5 : dcc_span_e'(span_r[1:0]);
            pair_span_out[1]         <= (span_r[3:2] == 2'h3) ? DCC_SPAN_0_TO_5 : dcc_span_e'(span_r[3:2]);
            aux_span_high_out        <= span_r[7:4];
        end
    end

    // Amplifier off while a sleep pin with its amp bit set is high
    always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            amplifier_enable_out <= 1'b0;
        end else begin
            amplifier_enable_out <= !((slp_a_s && mask_a_r[`DCC_AMP_BIT]) ||
                                      (slp_b_s && mask_b_r[`DCC_AMP_BIT]));
        end
    end

    always_comb begin
        rdata = 16'h0000;
        if (data_hit) begin
            rdata = {4'h0, active_r[addr[2:0]]};
        end else begin
            case (addr)
                `DCC_ADDR_SYNC:  rdata = {8'h00, sync_mode_r};
                `DCC_ADDR_SPAN:  rdata = {8'h00, span_r};
                `DCC_ADDR_CLAMP: rdata = {10'h000, sw_clamp_r};
                `DCC_ADDR_SLP_A: rdata = {8'h00, mask_a_r};
                `DCC_ADDR_SLP_B: rdata = {8'h00, mask_b_r};
                `DCC_ADDR_ALARM: rdata = {8'h00, alarm_mask_r};
                default:         rdata = 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_r);

    property p_read_active;
        rd_stb && addr == `DCC_ADDR_DATA0 |-> rdata[11:0] == active_r[0];
    endproperty
    a_read_active: assert property (p_read_active) else $error("data read not active value");

    property p_async_update;
        wr_stb && addr == `DCC_ADDR_DATA0 && !sync_mode_r[0] |=> active_r[0] == $past(wdata[11:0]);
    endproperty
    a_async_update: assert property (p_async_update) else $error("immediate update missed");

    property p_sync_hold;
        wr_stb && addr == `DCC_ADDR_DATA0 && sync_mode_r[0] && !trig_pulse |=> $stable(active_r[0]);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("synchronized channel moved early");

    property p_trigger_all;
        trig_pulse && sync_mode_r[0] && sync_mode_r[7] && !wr_stb
            |=> active_r[0] == $past(buf_r[0]) && active_r[7] == $past(buf_r[7]);
    endproperty
    a_trigger_all: assert property (p_trigger_all) else $error("trigger did not move all");

    property p_sleep_clamps;
        slp_a_s && mask_a_r[2] |=> channel_clamp_out[4];
    endproperty
    a_sleep_clamps: assert property (p_sleep_clamps) else $error("sleep did not clamp");

    property p_write_ignored;
        wr_stb && addr == `DCC_ADDR_CLAMP && sleep_force[0] && !mask_a_r[`DCC_LATCHED_REL_BIT]
            && !mask_b_r[`DCC_LATCHED_REL_BIT] && !alarm_rise |=> $stable(sw_clamp_r[0]);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("clamp write under sleep");

    property p_alarm_latch;
        alarm_rise && alarm_mask_r[3] |=> sw_clamp_r[3] ##1 channel_clamp_out[5];
    endproperty
    a_alarm_latch: assert property (p_alarm_latch) else $error("alarm clamp not latched");

    property p_supply_fault;
        fault_s |=> channel_clamp_out[3:0] == 4'hf && pair_clamp_to_supply_out == 2'h3;
    endproperty
    a_supply_fault: assert property (p_supply_fault) else $error("supply fault clamp missing");

    property p_trig_reads_zero;
        rd_stb && addr == `DCC_ADDR_TRIG |-> rdata == 16'h0000;
    endproperty
    a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger reads nonzero");

    property p_clamp_keeps_code;
        channel_clamp_out[1] && !wr_stb && !trig_pulse |=> $stable(channel_code_out[1]);
    endproperty
    a_clamp_keeps_code: assert property (p_clamp_keeps_code) else $error("clamp changed code");
endmodule
`default_nettype wire

// ==== verif/dcc_host_model.sv ====
/* Host model driving the four-wire register port with 24-bit frames.
   Assumes a 50 MHz clk_in; sclk idles low and stands still between frames. */
`timescale 1ns/1ps
`default_nettype none
module dcc_host_model (
    // System clock
    input  wire logic clk_in,
    // Serial pins
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    logic [23:0] frm;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // Five clocks per half period keeps sclk below clk/8
    task automatic hold();
        repeat (5) @(posedge clk_in);
    endtask
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] q);
        frm = {rd, a, wd};
        q = 16'h0000;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            hold();
            sclk_out <= 1'b0;
            mosi_out <= frm[i];
            hold();
            sclk_out <= 1'b1;
            if (i < 16) begin
                q = {q[14:0], miso_in};
            end
        end
        hold();
        sclk_out <= 1'b0;
        hold();
        cs_n_out <= 1'b1;
        // Released line shows the inverse, never a stale value
        mosi_out <= ~mosi_out;
        repeat (10) @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_dcc_dac_control.sv ====
/* Self-checking bench for the channel update and clamp control block.
   Assumes dcc_host_model as the serial host and the design's own assertions. */
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
`define EXPECT(g, e, m) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: %s", $time, m); end end
module tb_dcc_dac_control;
    import dcc_pkg::*;
    logic            clk_sys_in = 1'b0;
    logic            resetn_in = 1'b0;
    logic            sclk, cs_n, mosi, miso, miso_oe;
    logic [4:0]      pins = 5'h00;
    logic            oe_seen = 1'b0;
    localparam int   P_TRIG = 0;
    localparam int   P_SLPA = 1;
    localparam int   P_SLPB = 2;
    localparam int   P_ALARM = 3;
    localparam int   P_FAULT = 4;
    dcc_code_t [7:0] code;
    logic [7:0]      clamp;
    logic [1:0]      to_sup;
    dcc_span_e [1:0] pspan;
    logic [3:0]      aspan;
    logic            amp;
    int              error_cnt = 0;
    int              samples_checked = 0;
    int              cyc = 0;
    logic [31:0]     seed = 32'd17888;
    logic [31:0]     v;
    logic [15:0]     q;
    dcc_code_t       exp_c [8];
    dcc_code_t       pend [8];

    always #10 clk_sys_in = ~clk_sys_in;

    dcc_host_model dcc_host_model_i (.clk_in(clk_sys_in), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso));
    dcc_dac_control dcc_dac_control_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
        .converter_update_trigger_in(pins[0]), .sleep_pin_a_in(pins[1]), .sleep_pin_b_in(pins[2]),
        .alarm_output_in(pins[3]), .supply_fault_in(pins[4]), .channel_code_out(code),
        .channel_clamp_out(clamp), .pair_clamp_to_supply_out(to_sup), .pair_span_out(pspan),
        .aux_span_high_out(aspan), .amplifier_enable_out(amp));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Code 11 has no span of its own and falls back to 0..5 V
    function automatic dcc_span_e sp(input logic [1:0] c);
        return (c == 2'b11) ? DCC_SPAN_0_TO_5 : dcc_span_e'(c);
    endfunction
    task automatic wr(input dcc_addr_t a, input logic [15:0] d);
        dcc_host_model_i.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input dcc_addr_t a);
        dcc_host_model_i.xfer(1'b1, a, 16'h0000, q);
    endtask
    task automatic pin(input int k, input logic val);
        logic [4:0] nx;
        nx = pins;
        nx[k] = val;
        @(posedge clk_sys_in);
        pins <= nx;
        repeat (5) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic load(input logic [7:0] sm);
        for (int c = 0; c < 8; c++) begin
            v = rnd();
            pend[c] = (c == 0) ? 12'h800 : ((c == 7) ? 12'hfff : v[11:0]);
            wr(dcc_addr_t'(`DCC_ADDR_DATA0 + c), {v[15:12], pend[c]});
            if (!sm[c]) exp_c[c] = pend[c];
        end
    endtask
    task automatic fire(input logic [7:0] sm);
        for (int c = 0; c < 8; c++) if (sm[c]) exp_c[c] = pend[c];
    endtask
    task automatic chk_codes();
        for (int c = 0; c < 8; c++) begin
            `EXPECT(code[c], exp_c[c], "channel code")
            rd(dcc_addr_t'(`DCC_ADDR_DATA0 + c));
            `EXPECT(q, {4'h0, exp_c[c]}, "code read back")
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cyc++;
        if (!cs_n && miso_oe) begin
            oe_seen <= 1'b1;
        end
        if (cyc == 60000) begin
            error_cnt++;
            $display("unexpected at %0t: run too long", $time);
            print_verdict();
        end
    end

    initial begin
        for (int c = 0; c < 8; c++) exp_c[c] = 12'h000;
        repeat (16) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        #1;
        `EXPECT(clamp, 8'hff, "reset clamp")
        `EXPECT(miso_oe, 1'b0, "serial output idle")
        chk_codes();
        rd(`DCC_ADDR_CLAMP);
        `EXPECT(q, 16'h003f, "clamp reg reset")
        rd(7'h20);
        `EXPECT(q, 16'h0000, "unmapped read")
        wr(`DCC_ADDR_CLAMP, 16'h0000);
        `EXPECT(clamp, 8'h00, "software release")
        $display("test reset done");
        load(8'h00);
        chk_codes();
        wr(`DCC_ADDR_SYNC, 16'h00a5);
        load(8'ha5);
        chk_codes();
        wr(`DCC_ADDR_TRIG, 16'h0001);
        fire(8'ha5);
        chk_codes();
        rd(`DCC_ADDR_TRIG);
        `EXPECT(q, 16'h0000, "trigger reads zero")
        load(8'ha5);
        pin(P_TRIG, 1'b1);
        fire(8'ha5);
        pin(P_TRIG, 1'b0);
        chk_codes();
        $display("test update done");
        wr(`DCC_ADDR_SYNC, 16'h0000);
        wr(`DCC_ADDR_CLAMP, 16'h003f);
        `EXPECT(clamp, 8'hff, "clamp all")
        chk_codes();
        load(8'h00);
        wr(`DCC_ADDR_CLAMP, 16'h0000);
        `EXPECT(clamp, 8'h00, "unclamp")
        chk_codes();
        $display("test clamp done");
        for (int j = 0; j < 4; j++) begin
            v = rnd();
            wr(`DCC_ADDR_SPAN, {8'h00, v[7:4], 2'(~j), 2'(j)});
            `EXPECT(pspan[0], sp(2'(j)), "pair a span")
            `EXPECT(pspan[1], sp(2'(~j)), "pair b span")
            `EXPECT(aspan, v[7:4], "aux span")
        end
        $display("test span done");
        wr(`DCC_ADDR_SLP_A, 16'h0085);
        pin(P_SLPA, 1'b1);
        `EXPECT(clamp, 8'h13, "sleep a clamps")
        `EXPECT(to_sup, 2'b00, "ref pin clamp")
        `EXPECT(amp, 1'b0, "amplifier off")
        wr(`DCC_ADDR_CLAMP, 16'h0001);
        pin(P_SLPA, 1'b0);
        `EXPECT(clamp, 8'h00, "held bit write ignored")
        `EXPECT(amp, 1'b1, "amplifier on")
        wr(`DCC_ADDR_SLP_B, 16'h0044);
        pin(P_SLPB, 1'b1);
        `EXPECT(clamp, 8'h10, "sleep b clamps")
        `EXPECT(amp, 1'b1, "amplifier unmasked")
        pin(P_SLPB, 1'b0);
        `EXPECT(clamp, 8'h10, "latched release holds")
        wr(`DCC_ADDR_CLAMP, 16'h0000);
        `EXPECT(clamp, 8'h00, "latched release write")
        $display("test sleep done");
        wr(`DCC_ADDR_ALARM, 16'h002a);
        pin(P_ALARM, 1'b1);
        `EXPECT(clamp, 8'hac, "alarm clamps")
        pin(P_ALARM, 1'b0);
        `EXPECT(clamp, 8'hac, "alarm fall holds")
        wr(`DCC_ADDR_CLAMP, 16'h0000);
        `EXPECT(clamp, 8'h00, "alarm release")
        pin(P_FAULT, 1'b1);
        `EXPECT(to_sup, 2'b11, "supply clamp mode")
        `EXPECT(clamp, 8'h0f, "bipolar clamped")
        `EXPECT(code[0], exp_c[0], "code kept")
        pin(P_FAULT, 1'b0);
        `EXPECT(to_sup, 2'b00, "supply ok")
        `EXPECT(clamp, 8'h00, "fault gone")
        `EXPECT(oe_seen, 1'b1, "serial output enabled in frame")
        $display("test alarm and fault done");
        print_verdict();
    end
endmodule
`default_nettype wire
